// *** hw/ppt_timer.sv ***
// Top of the prescaled periodic timer: I/O register port, prescaler and
// main counter, interrupt flag and mask, and the pulse output.
// Assumes the processor I/O port strobes are one cycle long and synchronous
// to clock_in, which is the processor output clock.
// Assumes a read and a write are never strobed in the same clock, and that
// software samples read data one clock after the read strobe.

`timescale 1ns/1ps

// Notes on behaviour
// - Twenty-bit timer built from a 16-bit main and 4-bit prescale down-counter.
// - Start loads main count from period and prescale count from divide-down.
// - While running, the prescale count falls by one every clock.
// - After prescale reaches zero, reload it and step the main count down.
// - After main count reaches zero, reload it from period; new interval begins.
// - Each main count terminal event sets the timer interrupt flag; the mask gates the request.
// - Each main count terminal event gives a one-clock pulse on the pin.
// - Main count and period are 16-bit registers in I/O space.
// - Prescale and divide-down are 4-bit fields of the control register.
// - Timer interrupt has its own mask bit and settable, clearable flag bit.
module ppt_timer (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_write_in,
    input wire logic io_read_in,
    input wire logic [15:0] io_wdata_in,
    output logic [15:0] io_rdata_out,
    output logic timer_irq_out,
    output logic timer_pulse_out
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Every register is decoded on the full I/O address, so the block never
    // answers at an alias. Strobes may come back to back, one per clock.
    logic wr_main;
    logic wr_period;
    logic wr_control;
    logic wr_mask;
    logic wr_flag;
    logic wr_flag_set;

    assign wr_main = io_write_in && (io_addr_in == ppt_pkg::ADDR_MAIN_COUNT);
    assign wr_period = io_write_in && (io_addr_in == ppt_pkg::ADDR_PERIOD_VALUE);
    assign wr_control = io_write_in && (io_addr_in == ppt_pkg::ADDR_TIMER_CONTROL);
    assign wr_mask = io_write_in && (io_addr_in == ppt_pkg::ADDR_IRQ_MASK);
    assign wr_flag = io_write_in && (io_addr_in == ppt_pkg::ADDR_IRQ_FLAG);
    assign wr_flag_set = io_write_in && (io_addr_in == ppt_pkg::ADDR_IRQ_FLAG_SET);

    // Fields of a control write. The reload bit is a command and is never
    // stored, so it always reads back as zero.
    logic [3:0] wdata_divide;
    logic wdata_stop;
    logic wdata_reload;

    assign wdata_divide = io_wdata_in[ppt_pkg::TCR_DIVIDE_LSB +: ppt_pkg::PRESCALE_WIDTH];
    assign wdata_stop = io_wdata_in[ppt_pkg::TCR_STOP_BIT];
    assign wdata_reload = io_wdata_in[ppt_pkg::TCR_RELOAD_BIT];

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [15:0] period_value;
    logic [3:0] divide_down_value;
    logic timer_stopped;
    logic irq_mask;
    logic [15:0] next_period_value;
    logic [3:0] next_divide_down_value;
    logic next_timer_stopped;
    logic next_irq_mask;

    // A new period takes effect at the next reload and never disturbs the
    // running count. The stop bit is written by every control write, so one
    // write that carries the reload command can both load and start.
    // The mask holds a single bit for this timer; its other bits read as zero.
    always_comb begin
        next_period_value = period_value;
        next_divide_down_value = divide_down_value;
        next_timer_stopped = timer_stopped;
        next_irq_mask = irq_mask;
        if (wr_period) begin
            next_period_value = io_wdata_in;
        end
        if (wr_control) begin
            next_divide_down_value = wdata_divide;
            next_timer_stopped = wdata_stop;
        end
        if (wr_mask) begin
            next_irq_mask = io_wdata_in[ppt_pkg::IRQ_TIMER_BIT];
        end
    end

    // Reset leaves the timer stopped so nothing counts before software has
    // programmed the period and the divide-down value.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            period_value <= ppt_pkg::RESET_PERIOD;
            divide_down_value <= ppt_pkg::RESET_DIVIDE;
            timer_stopped <= 1'b1;
            irq_mask <= 1'b0;
        end else begin
            period_value <= next_period_value;
            divide_down_value <= next_divide_down_value;
            timer_stopped <= next_timer_stopped;
            irq_mask <= next_irq_mask;
        end
    end

    // ------------------------------------------------------------------
    // Counting stages
    // ------------------------------------------------------------------
    // With divide-down D and period P the prescale count runs from D down to
    // zero and reloads on the next clock, so the main count moves once every
    // D+1 clocks. The main count runs from P down to zero and reloads at its
    // next step, which is the terminal event, so events come every
    // (D+1)*(P+1) clocks.

    logic start_load;
    logic running;
    logic [3:0] prescale_count;
    logic prescale_zero;
    logic [15:0] main_count;
    logic main_zero;
    logic main_step;
    logic terminal;
    logic prescale_load;
    logic [3:0] prescale_load_value;
    logic main_load;
    logic [15:0] main_load_value;

    // The reload command uses the divide-down value written with it, so a
    // single control write both programs and starts the prescaler.
    assign start_load = wr_control && wdata_reload;
    // Clearing the stop bit without the reload command resumes from the
    // frozen counts, which lets software pause and continue an interval.
    assign running = !timer_stopped;
    assign main_step = running && prescale_zero;
    assign terminal = main_step && main_zero;

    // Load priority: the reload command beats everything, then a software
    // write of the main count, then the terminal reload. A software write in
    // the clock of a terminal event still lets that event be flagged.
    always_comb begin
        prescale_load = 1'b0;
        prescale_load_value = divide_down_value;
        main_load = 1'b0;
        main_load_value = period_value;
        if (start_load) begin
            prescale_load = 1'b1;
            prescale_load_value = wdata_divide;
            main_load = 1'b1;
        end else begin
            if (main_step) begin
                prescale_load = 1'b1;
            end
            if (wr_main) begin
                main_load = 1'b1;
                main_load_value = io_wdata_in;
            end else if (terminal) begin
                main_load = 1'b1;
            end
        end
    end

    // The prescale stage counts every clock while the timer runs; inside the
    // counter a load beats a decrement, so the reload never loses a clock.
    ppt_down_counter #(
        .WIDTH(ppt_pkg::PRESCALE_WIDTH)
    ) u_prescale (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .reset_value_in(ppt_pkg::RESET_PRESCALE),
        .load_in(prescale_load),
        .load_value_in(prescale_load_value),
        .dec_in(running),
        .count_out(prescale_count),
        .zero_out(prescale_zero)
    );

    // The main stage steps only in the clock after the prescale stage has
    // reached zero.
    ppt_down_counter #(
        .WIDTH(ppt_pkg::MAIN_WIDTH)
    ) u_main (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .reset_value_in(ppt_pkg::RESET_MAIN),
        .load_in(main_load),
        .load_value_in(main_load_value),
        .dec_in(main_step),
        .count_out(main_count),
        .zero_out(main_zero)
    );

    // ------------------------------------------------------------------
    // Interrupt and pulse
    // ------------------------------------------------------------------
    logic irq_flag;
    logic pulse;
    logic next_pulse;
    logic sw_set_flag;
    logic sw_clear_flag;

    // Both flag addresses act only on the timer bit; a write with that bit
    // low leaves the flag alone.
    assign sw_set_flag = wr_flag_set && io_wdata_in[ppt_pkg::IRQ_TIMER_BIT];
    assign sw_clear_flag = wr_flag && io_wdata_in[ppt_pkg::IRQ_TIMER_BIT];

    // A terminal event in the clock of a software clear sets the flag again,
    // so no event is lost to a late clear.
    ppt_irq_bit u_irq (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .hw_set_in(terminal),
        .sw_set_in(sw_set_flag),
        .sw_clear_in(sw_clear_flag),
        .flag_out(irq_flag)
    );

    // The mask gates only the request line; the flag keeps recording events
    // while masked, so software can still poll it.
    assign timer_irq_out = irq_flag && irq_mask;

    // The pulse is registered so the pin never glitches on decode hazards; it
    // rises one clock after the terminal event, together with the flag.
    always_comb begin
        next_pulse = terminal;
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pulse <= 1'b0;
        end else begin
            pulse <= next_pulse;
        end
    end

    assign timer_pulse_out = pulse;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic [15:0] control_word;

    // The prescale field is read-only and shows the live prescale count.
    always_comb begin
        control_word = ppt_pkg::READ_ZERO;
        control_word[ppt_pkg::TCR_DIVIDE_LSB +: ppt_pkg::PRESCALE_WIDTH] = divide_down_value;
        control_word[ppt_pkg::TCR_STOP_BIT] = timer_stopped;
        control_word[ppt_pkg::TCR_PRESCALE_LSB +: ppt_pkg::PRESCALE_WIDTH] = prescale_count;
    end

    // Unmapped addresses and idle cycles read as zero, so the read data of
    // several blocks on one port can simply be ORed together.
    always_comb begin
        next_rdata = ppt_pkg::READ_ZERO;
        if (io_read_in) begin
            case (io_addr_in)
                ppt_pkg::ADDR_MAIN_COUNT: begin
                    next_rdata = main_count;
                end
                ppt_pkg::ADDR_PERIOD_VALUE: begin
                    next_rdata = period_value;
                end
                ppt_pkg::ADDR_TIMER_CONTROL: begin
                    next_rdata = control_word;
                end
                ppt_pkg::ADDR_IRQ_MASK: begin
                    next_rdata[ppt_pkg::IRQ_TIMER_BIT] = irq_mask;
                end
                // Reading the flag has no side effect; only a write of one clears it.
                ppt_pkg::ADDR_IRQ_FLAG: begin
                    next_rdata[ppt_pkg::IRQ_TIMER_BIT] = irq_flag;
                end
                // The set address is a write-only strobe.
                ppt_pkg::ADDR_IRQ_FLAG_SET: begin
                    next_rdata = ppt_pkg::READ_ZERO;
                end
                default: begin
                    next_rdata = ppt_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // Registered read data costs one clock of latency but keeps decode
    // hazards off the bus.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata <= ppt_pkg::READ_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign io_rdata_out = rdata;

endmodule // ppt_timer

// *** hw/ppt_pkg.sv ***
// Package of the prescaled periodic timer: I/O addresses, control field
// layout and reset values.
// Assumes a processor I/O port with 16-bit addresses and 16-bit data.

package ppt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int MAIN_WIDTH = 16;
    localparam int PRESCALE_WIDTH = 4;
    localparam int IO_ADDR_WIDTH = 16;
    localparam int IO_DATA_WIDTH = 16;

    // ------------------------------------------------------------------
    // I/O addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_MAIN_COUNT = 16'h0010;
    localparam logic [15:0] ADDR_PERIOD_VALUE = 16'h0011;
    localparam logic [15:0] ADDR_TIMER_CONTROL = 16'h0012;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0013;
    localparam logic [15:0] ADDR_IRQ_FLAG = 16'h0014;
    localparam logic [15:0] ADDR_IRQ_FLAG_SET = 16'h0015;

    // ------------------------------------------------------------------
    // Timer control register fields
    // ------------------------------------------------------------------
    localparam int TCR_DIVIDE_LSB = 0;
    localparam int TCR_STOP_BIT = 4;
    localparam int TCR_RELOAD_BIT = 5;
    localparam int TCR_PRESCALE_LSB = 6;

    // Bit of the timer in the interrupt mask and flag registers.
    localparam int IRQ_TIMER_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RESET_PERIOD = 16'hFFFF;
    localparam logic [15:0] RESET_MAIN = 16'hFFFF;
    localparam logic [3:0] RESET_DIVIDE = 4'h0;
    localparam logic [3:0] RESET_PRESCALE = 4'h0;
    localparam logic [15:0] READ_ZERO = 16'h0000;

endpackage

// *** hw/ppt_down_counter.sv ***
// Loadable down-counter with a terminal flag, used for both timer stages.
// Assumes load and decrement requests come from logic on the same clock.

`timescale 1ns/1ps

module ppt_down_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] reset_value_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_value_in,
    input wire logic dec_in,
    output logic [WIDTH-1:0] count_out,
    output logic zero_out
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load takes priority so software and reload always see the new value.
    always_comb begin
        next_count = count;
        if (load_in) begin
            next_count = load_value_in;
        end else if (dec_in) begin
            next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count <= reset_value_in;
        end else begin
            count <= next_count;
        end
    end

    assign count_out = count;
    assign zero_out = (count == {WIDTH{1'b0}});

endmodule // ppt_down_counter

// *** hw/ppt_irq_bit.sv ***
// One interrupt flag with hardware set, software set and software clear.
// Assumes all requests are single-cycle strobes on the same clock.

`timescale 1ns/1ps

module ppt_irq_bit (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic hw_set_in,
    input wire logic sw_set_in,
    input wire logic sw_clear_in,
    output logic flag_out
);

    logic flag;
    logic next_flag;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        next_flag = flag;
        if (sw_clear_in) begin
            next_flag = 1'b0;
        end
        if (hw_set_in || sw_set_in) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    assign flag_out = flag;

endmodule // ppt_irq_bit

// *** verification/ppt_timer_assertions.sv ***
// Checker of the prescaled periodic timer, watching only the top ports.
// Assumes ppt_pkg is compiled first and the bind below finds ppt_timer.
`timescale 1ns/1ps
module ppt_timer_checker (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_write_in,
    input wire logic io_read_in,
    input wire logic [15:0] io_wdata_in,
    input wire logic [15:0] io_rdata_out,
    input wire logic timer_irq_out,
    input wire logic timer_pulse_out
);
    default clocking @(posedge clock_in); endclocking
    logic rd_ctl;
    logic rd_irq;
    logic rd_none;
    logic rd_flag;
    logic clr;
    assign rd_ctl = io_read_in && io_addr_in == ppt_pkg::ADDR_TIMER_CONTROL;
    assign rd_flag = io_read_in && io_addr_in == ppt_pkg::ADDR_IRQ_FLAG;
    assign rd_irq = rd_flag || (io_read_in && io_addr_in == ppt_pkg::ADDR_IRQ_MASK);
    assign rd_none = io_read_in &&
        (io_addr_in < ppt_pkg::ADDR_MAIN_COUNT || io_addr_in > ppt_pkg::ADDR_IRQ_FLAG);
    assign clr = io_write_in && io_addr_in == ppt_pkg::ADDR_IRQ_FLAG && io_wdata_in[0];
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    AST_RESET_QUIET: assert property (reset_in |=> io_rdata_out == 16'h0000 &&
        !timer_irq_out && !timer_pulse_out) else $error("outputs busy after reset");
    AST_RDATA_IDLE: assert property (disable iff (reset_in)
        !io_read_in |=> io_rdata_out == 16'h0000) else $error("read data without read");
    AST_UNMAPPED_ZERO: assert property (disable iff (reset_in)
        rd_none |=> io_rdata_out == 16'h0000) else $error("unmapped read not zero");
    AST_CTRL_FIELDS: assert property (disable iff (reset_in) rd_ctl |=>
        io_rdata_out[15:10] == 6'h00 && !io_rdata_out[5]) else $error("control bits");
    AST_IRQ_REG_BITS: assert property (disable iff (reset_in)
        rd_irq |=> io_rdata_out[15:1] == 15'h0000) else $error("irq register bits");
    AST_FLAG_READ: assert property (disable iff (reset_in)
        rd_flag && timer_irq_out |=> io_rdata_out[0]) else $error("flag reads low");
    AST_FLAG_CLEAR: assert property (disable iff (reset_in)
        clr |=> !timer_irq_out || timer_pulse_out) else $error("flag not cleared");
    AST_PULSE_ONE: assert property (disable iff (reset_in)
        timer_pulse_out |=> !timer_pulse_out) else $error("pulse too long");
    AST_IRQ_PULSE: assert property (disable iff (reset_in)
        $rose(timer_irq_out) && !$past(io_write_in) |-> timer_pulse_out)
        else $error("irq without pulse");
    cover property (timer_pulse_out);
    cover property ($rose(timer_irq_out));
    cover property (clr ##1 !timer_irq_out);
endmodule // ppt_timer_checker
bind ppt_timer ppt_timer_checker u_checker (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .io_addr_in(io_addr_in),
    .io_write_in(io_write_in),
    .io_read_in(io_read_in),
    .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out),
    .timer_irq_out(timer_irq_out),
    .timer_pulse_out(timer_pulse_out)
);

// *** verification/prescaled_periodic_timer_bench.sv ***
// Self-checking bench of the prescaled periodic timer through its I/O port.
// Assumes ppt_pkg, the design and the checker are compiled before it.
`timescale 1ns/1ps
module prescaled_periodic_timer_bench;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] io_addr_in = 16'h0000;
    logic io_write_in = 1'b0;
    logic io_read_in = 1'b0;
    logic [15:0] io_wdata_in = 16'h0000;
    logic [15:0] io_rdata_out;
    logic timer_irq_out;
    logic timer_pulse_out;
    logic [15:0] tp [3] = '{16'h0001, 16'h0002, 16'h0000};
    logic [15:0] td [3] = '{16'h0000, 16'h0001, 16'h000F};
    int n_mismatch = 0;
    int checks = 0;
    int n;
    ppt_timer uut (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .io_addr_in(io_addr_in),
        .io_write_in(io_write_in),
        .io_read_in(io_read_in),
        .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out),
        .timer_irq_out(timer_irq_out),
        .timer_pulse_out(timer_pulse_out)
    );
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clock_in);
        io_addr_in = a;
        io_wdata_in = d;
        io_write_in = 1'b1;
        @(negedge clock_in);
        io_write_in = 1'b0;
    endtask
    // Read data is registered, so it is valid at the negedge after the strobe.
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clock_in);
        io_addr_in = a;
        io_read_in = 1'b1;
        @(negedge clock_in);
        io_read_in = 1'b0;
        check(io_rdata_out, exp);
    endtask
    // Counts cycles up to the next pulse; a lost pulse ends the run.
    task automatic wait_pulse(output int k);
        k = 0;
        do begin
            @(negedge clock_in);
            k++;
        end while (timer_pulse_out !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_mismatch++;
            $display("ERROR %0t no timer pulse", $time);
            give_verdict();
        end
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        @(negedge clock_in);
        reset_in = 1'b0;
        rd(ppt_pkg::ADDR_PERIOD_VALUE, ppt_pkg::RESET_PERIOD);
        rd(ppt_pkg::ADDR_MAIN_COUNT, ppt_pkg::RESET_MAIN);
        rd(ppt_pkg::ADDR_TIMER_CONTROL, 16'h0010);
        rd(ppt_pkg::ADDR_IRQ_MASK, 16'h0000);
        rd(ppt_pkg::ADDR_IRQ_FLAG_SET, 16'h0000);
        rd(16'h0016, 16'h0000);
        wr(ppt_pkg::ADDR_MAIN_COUNT, 16'hABCD);
        rd(ppt_pkg::ADDR_MAIN_COUNT, 16'hABCD);
        wr(ppt_pkg::ADDR_TIMER_CONTROL, 16'h001F);
        rd(ppt_pkg::ADDR_TIMER_CONTROL, 16'h001F);
        wr(ppt_pkg::ADDR_PERIOD_VALUE, 16'h0007);
        wr(ppt_pkg::ADDR_TIMER_CONTROL, 16'h0033);
        rd(ppt_pkg::ADDR_TIMER_CONTROL, 16'h00D3);
        rd(ppt_pkg::ADDR_MAIN_COUNT, 16'h0007);
        wr(ppt_pkg::ADDR_IRQ_MASK, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            wr(ppt_pkg::ADDR_PERIOD_VALUE, tp[i]);
            wr(ppt_pkg::ADDR_TIMER_CONTROL, td[i] | 16'h0020);
            wait_pulse(n);
            wait_pulse(n);
            check(n[15:0], (td[i] + 16'h0001) * (tp[i] + 16'h0001));
        end
        check({15'h0000, timer_irq_out}, 16'h0001);
        wr(ppt_pkg::ADDR_TIMER_CONTROL, 16'h0010);
        wr(ppt_pkg::ADDR_MAIN_COUNT, 16'h0005);
        repeat (20) @(negedge clock_in);
        rd(ppt_pkg::ADDR_MAIN_COUNT, 16'h0005);
        rd(ppt_pkg::ADDR_IRQ_FLAG, 16'h0001);
        wr(ppt_pkg::ADDR_IRQ_FLAG, 16'h0000);
        rd(ppt_pkg::ADDR_IRQ_FLAG, 16'h0001);
        wr(ppt_pkg::ADDR_IRQ_FLAG, 16'h0001);
        rd(ppt_pkg::ADDR_IRQ_FLAG, 16'h0000);
        check({15'h0000, timer_irq_out}, 16'h0000);
        wr(ppt_pkg::ADDR_IRQ_FLAG_SET, 16'h0001);
        check({15'h0000, timer_irq_out}, 16'h0001);
        wr(ppt_pkg::ADDR_IRQ_MASK, 16'h0000);
        check({15'h0000, timer_irq_out}, 16'h0000);
        rd(ppt_pkg::ADDR_IRQ_FLAG, 16'h0001);
        wr(ppt_pkg::ADDR_TIMER_CONTROL, 16'h0021);
        repeat (7) @(negedge clock_in);
        reset_in = 1'b1;
        repeat (3) @(negedge clock_in);
        reset_in = 1'b0;
        rd(ppt_pkg::ADDR_TIMER_CONTROL, 16'h0010);
        rd(ppt_pkg::ADDR_MAIN_COUNT, ppt_pkg::RESET_MAIN);
        give_verdict();
    end
endmodule // prescaled_periodic_timer_bench
